// ===== fanp_top.v
// Fiber auto-negotiation next-page register bank with APB slave
`timescale 1ns/1ns
`include "fanp_regs.vh"
module fanp_top (
  // APB
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Link side events from the negotiation engine
  input  wire        link_up,
  input  wire        sync_ok,
  input  wire        cfg_valid,
  input  wire [15:0] cfg_word,
  input  wire        base_page_rx,
  input  wire        next_page_rx,
  input  wire [15:0] rx_code_word,
  // Towards the negotiation engine
  output reg         np_loaded,
  output reg  [15:0] tx_np_word,
  output reg         tx_np_valid,
  // Interrupt
  output reg         irq
);
  // Synchronised link inputs
  reg        link_s1_r, link_s2_r, sync_s1_r, sync_s2_r;
  reg        cv_s1_r, cv_s2_r, bp_s1_r, bp_s2_r, np_s1_r, np_s2_r;
  reg [15:0] cw_s1_r, cw_s2_r, rx_s1_r, rx_s2_r;
  reg        link_d_r;
  reg        bp_d_r, np_d_r;
  // Register state
  reg        partner_np_r;
  reg        page_rx_r;
  reg        an_able_latch_r;
  reg [15:0] np_tx_r;
  reg        toggle_r;
  reg [15:0] partner_word_r;
  reg [1:0]  mode_r;
  reg        an_en_r;
  reg [2:0]  irq_stat_r;
  reg [2:0]  irq_en_r;
  wire       cfg_able;

  // Decoded strobes
  wire       acc     = psel && penable;
  wire       wr      = acc && pwrite;
  wire       rd      = acc && !pwrite;
  wire [3:0] idx     = paddr[5:2];
  wire       aligned = (paddr[1:0] == 2'h0) && (paddr[7:6] == 2'h0);
  wire       is_1000x = (mode_r == `FANP_MODE_1000X);
  // One event per pulse, however many cycles the engine holds it
  wire       bp_rise = bp_s2_r && !bp_d_r;
  wire       np_rise = np_s2_r && !np_d_r;
  wire       page_ev = bp_rise || np_rise;
  wire       link_dn_ev = link_d_r && !link_s2_r;

  // Map an index to a known register
  function mapped;
    input [3:0] i;
    begin
      mapped = (i == `FANP_IDX_EXPANSION) || (i == `FANP_IDX_NP_TX) ||
               (i == `FANP_IDX_PARTNER_NP) || (i == `FANP_IDX_EXT_STATUS) ||
               (i == `FANP_IDX_MODE_CTRL) || (i == `FANP_IDX_IRQ_STATUS) ||
               (i == `FANP_IDX_IRQ_ENABLE) || (i == `FANP_IDX_IRQ_CLEAR);
    end
  endfunction

  wire hit = aligned && mapped(idx);

  // Two-flop synchronisers on everything from the link domain
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_s1_r <= 1'b0;
      link_s2_r <= 1'b0;
      sync_s1_r <= 1'b0;
      sync_s2_r <= 1'b0;
      cv_s1_r   <= 1'b0;
      cv_s2_r   <= 1'b0;
      bp_s1_r   <= 1'b0;
      bp_s2_r   <= 1'b0;
      np_s1_r   <= 1'b0;
      np_s2_r   <= 1'b0;
      cw_s1_r   <= 16'h0000;
      cw_s2_r   <= 16'h0000;
      rx_s1_r   <= 16'h0000;
      rx_s2_r   <= 16'h0000;
      link_d_r  <= 1'b0;
      bp_d_r    <= 1'b0;
      np_d_r    <= 1'b0;
    end else begin
      link_s1_r <= link_up;
      link_s2_r <= link_s1_r;
      sync_s1_r <= sync_ok;
      sync_s2_r <= sync_s1_r;
      cv_s1_r   <= cfg_valid;
      cv_s2_r   <= cv_s1_r;
      bp_s1_r   <= base_page_rx;
      bp_s2_r   <= bp_s1_r;
      np_s1_r   <= next_page_rx;
      np_s2_r   <= np_s1_r;
      cw_s1_r   <= cfg_word;
      cw_s2_r   <= cw_s1_r;
      rx_s1_r   <= rx_code_word;
      rx_s2_r   <= rx_s1_r;
      link_d_r  <= link_s2_r;
      bp_d_r    <= bp_s2_r;
      np_d_r    <= np_s2_r;
    end
  end

  // Config code group matcher
  fanp_cfg_detect u_cfg (
    .pclk      (pclk),
    .presetn   (presetn),
    .sync_ok   (sync_s2_r),
    .cfg_valid (cv_s2_r),
    .cfg_word  (cw_s2_r),
    .able_r    (cfg_able)
  );

  // Page status, toggle and partner word
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      partner_np_r    <= 1'b0;
      page_rx_r       <= 1'b0;
      toggle_r        <= 1'b0;
      partner_word_r  <= 16'h0000;
      an_able_latch_r <= 1'b0;
    end else begin
      if (!link_s2_r) begin
        partner_np_r <= 1'b0;
      end else if (bp_s2_r && is_1000x) begin
        partner_np_r <= rx_s2_r[`FANP_CW_NP];
      end
      // latch page received; clear only after a read returned it set
      if (page_ev) begin
        page_rx_r <= 1'b1;
      end else if (rd && hit && idx == `FANP_IDX_EXPANSION && prdata[`FANP_EXP_PAGE_RX]) begin
        page_rx_r <= 1'b0;
      end
      if (page_ev) begin
        toggle_r <= ~toggle_r;
      end
      if (!link_s2_r) begin
        partner_word_r <= 16'h0000;
      end else if (np_s2_r && is_1000x) begin
        partner_word_r <= rx_s2_r;
      end
      // partner autoneg able only while all conditions hold
      an_able_latch_r <= cfg_able && sync_s2_r && an_en_r;
    end
  end

  // Software registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      np_tx_r  <= `FANP_NP_TX_RST;
      mode_r   <= `FANP_MODE_RST;
      an_en_r  <= `FANP_AN_EN_RST;
      irq_en_r <= 3'h0;
    end else if (wr && hit) begin
      case (idx)
        // writable bits only; bit 11 and 14 not stored here
        `FANP_IDX_NP_TX: begin
          if (pstrb[0]) np_tx_r[7:0] <= pwdata[7:0];
          if (pstrb[1]) np_tx_r[15:8] <= {pwdata[15], 1'b0, pwdata[13:12], 1'b0,
                                          pwdata[10:8]};
        end
        // mode field in bits 1:0, autoneg enable in bit 2
        `FANP_IDX_MODE_CTRL: begin
          if (pstrb[0]) begin
            mode_r  <= pwdata[1:0];
            an_en_r <= pwdata[2];
          end
        end
        `FANP_IDX_IRQ_ENABLE: begin
          if (pstrb[0]) irq_en_r <= pwdata[2:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Sticky interrupt status: an event in the clear cycle wins
  wire [2:0] irq_ev  = {link_dn_ev, np_rise, page_ev};
  wire [2:0] irq_clr = (wr && hit && idx == `FANP_IDX_IRQ_CLEAR && pstrb[0]) ?
                       pwdata[2:0] : 3'h0;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_r <= 3'h0;
      irq        <= 1'b0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_ev;
      irq        <= |(((irq_stat_r & ~irq_clr) | irq_ev) & irq_en_r);
    end
  end

  // Next-page handoff to the negotiation engine
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      np_loaded   <= 1'b0;
      tx_np_word  <= 16'h0000;
      tx_np_valid <= 1'b0;
    end else begin
      // any write to the transmit register loads a next page, only in 1000BASE-X
      np_loaded   <= wr && hit && (idx == `FANP_IDX_NP_TX) && is_1000x;
      // code word carries hardware toggle in bit 11
      tx_np_word  <= {np_tx_r[15], 1'b0, np_tx_r[13:12], toggle_r, np_tx_r[10:0]};
      tx_np_valid <= is_1000x;
    end
  end

  // Read mux
  reg [15:0] rdata;
  always @* begin
    rdata = 16'h0000;
    case (idx)
      `FANP_IDX_EXPANSION: begin
        rdata[`FANP_EXP_PARTNER_NP] = partner_np_r && is_1000x;
        rdata[`FANP_EXP_LOCAL_NP]   = 1'b1;
        rdata[`FANP_EXP_PAGE_RX]    = page_rx_r;
        rdata[`FANP_EXP_PARTNER_AN] = an_able_latch_r;
      end
      `FANP_IDX_NP_TX: begin
        rdata = {np_tx_r[15], 1'b0, np_tx_r[13:12], toggle_r, np_tx_r[10:0]};
      end
      `FANP_IDX_PARTNER_NP: begin
        rdata = partner_word_r;
      end
      `FANP_IDX_EXT_STATUS: begin
        // X capability by mode, T bits stay zero
        rdata[`FANP_EXT_X_FD] = (mode_r != `FANP_MODE_100FX);
        rdata[`FANP_EXT_X_HD] = (mode_r != `FANP_MODE_100FX);
      end
      `FANP_IDX_MODE_CTRL: begin
        rdata[2:0] = {an_en_r, mode_r};
      end
      `FANP_IDX_IRQ_STATUS: begin
        rdata[2:0] = irq_stat_r;
      end
      `FANP_IDX_IRQ_ENABLE: begin
        rdata[2:0] = irq_en_r;
      end
      default: begin
        rdata = 16'h0000;
      end
    endcase
  end

  // APB answer: no wait state; the read data is registered from a flop in the setup cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      pready  <= 1'b1;
      prdata  <= (!pwrite && hit) ? {16'h0000, rdata} : 32'h00000000;
      pslverr <= !hit;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end
endmodule

// ===== fanp_regs.vh
// Register map, field positions and reset values for the fiber next-page bank
`ifndef FANP_REGS_VH
`define FANP_REGS_VH
// Register indices; byte address is four times the index
`define FANP_IDX_EXPANSION   4'h6
`define FANP_IDX_NP_TX       4'h7
`define FANP_IDX_PARTNER_NP  4'h8
`define FANP_IDX_EXT_STATUS  4'hf
// Own registers for mode, control, interrupts
`define FANP_IDX_MODE_CTRL   4'h9
`define FANP_IDX_IRQ_STATUS  4'ha
`define FANP_IDX_IRQ_ENABLE  4'hb
`define FANP_IDX_IRQ_CLEAR   4'hc
// Expansion fields
`define FANP_EXP_PARTNER_NP   3
`define FANP_EXP_LOCAL_NP     2
`define FANP_EXP_PAGE_RX      1
`define FANP_EXP_PARTNER_AN   0
// Code word fields
`define FANP_CW_NP            15
`define FANP_CW_ACK           14
`define FANP_CW_MP            13
`define FANP_CW_ACK2          12
`define FANP_CW_TOGGLE        11
// Extended status fields
`define FANP_EXT_X_FD         15
`define FANP_EXT_X_HD         14
// Reset values
`define FANP_NP_TX_RST        16'h2001
`define FANP_MODE_RST         2'h1
`define FANP_AN_EN_RST        1'h1
// Fiber mode encodings
`define FANP_MODE_SGMII_MEDIA 2'h3
`define FANP_MODE_SGMII_SYS   2'h2
`define FANP_MODE_1000X       2'h1
`define FANP_MODE_100FX       2'h0
// Matching config code groups needed
`define FANP_CFG_MATCH_CNT    2'h3
// Interrupt bits: page received, next page received, link lost
`define FANP_IRQ_PAGE         0
`define FANP_IRQ_NP           1
`define FANP_IRQ_LINKDN       2
`endif

// ===== fanp_cfg_detect.v
// Counter of consecutive matching non-zero configuration code groups
`timescale 1ns/1ns
`include "fanp_regs.vh"
module fanp_cfg_detect (
  // Clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // Receive side
  input  wire        sync_ok,
  input  wire        cfg_valid,
  input  wire [15:0] cfg_word,
  // Result
  output reg         able_r
);
  reg [15:0] last_r;
  reg [1:0]  cnt_r;

  // Restart the count on any mismatch, zero word or sync loss
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_r <= 16'h0000;
      cnt_r  <= 2'h0;
      able_r <= 1'b0;
    end else if (!sync_ok) begin
      cnt_r  <= 2'h0;
      able_r <= 1'b0;
    end else if (cfg_valid) begin
      last_r <= cfg_word;
      if (cfg_word == 16'h0000) begin
        cnt_r <= 2'h0;
      end else if (cfg_word != last_r || cnt_r == 2'h0) begin
        cnt_r <= 2'h1;
      end else if (cnt_r != `FANP_CFG_MATCH_CNT) begin
        cnt_r <= cnt_r + 2'h1;
      end
      able_r <= (cfg_word != 16'h0000) && (cfg_word == last_r) &&
                (cnt_r >= 2'h2);
    end
  end
endmodule

// ===== fanp_checker.sv
// Concurrent checks on the ports of the fiber next-page register bank
`timescale 1ns/1ns
module fanp_checker (
  // APB
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] prdata,
  input wire        pready,
  // Link events and engine side
  input wire        link_up,
  input wire        base_page_rx,
  input wire        next_page_rx,
  input wire        np_loaded,
  input wire [15:0] tx_np_word,
  input wire        tx_np_valid
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Completed read, completed write to the transmit register
  wire rd    = psel & penable & pready & ~pwrite;
  wire wr_np = psel & penable & pready & pwrite & (paddr == 8'h1c);
  reg  [3:0] down_r;
  reg  [3:0] age_r;
  // Cycles since link loss and since last page; saturating so they never wrap
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      down_r <= 4'h0;
      age_r  <= 4'hf;
    end else begin
      down_r <= link_up ? 4'h0 : down_r + {3'h0, down_r != 4'hf};
      age_r  <= (base_page_rx | next_page_rx) ? 4'h0 : age_r + {3'h0, age_r != 4'hf};
    end
  end
  a_local_np_one: assert property (rd && paddr == 8'h18 |-> prdata[2])
    else $error("local next page bit low");
  a_ext_t_zero: assert property (rd && paddr == 8'h3c |-> prdata[13:12] == 2'h0)
    else $error("copper duplex bits set");
  a_tx_rsvd_zero: assert property (rd && paddr == 8'h1c |-> !prdata[14] && !tx_np_word[14])
    else $error("transmit bit 14 set");
  a_np_load_write: assert property (wr_np && tx_np_valid |-> ##[1:2] np_loaded)
    else $error("next page load missing");
  a_np_load_cause: assert property ($rose(np_loaded) |-> $past(wr_np) || $past(wr_np, 2))
    else $error("next page load without write");
  a_np_mode_gate: assert property (np_loaded |-> tx_np_valid)
    else $error("next page load outside 1000X");
  a_toggle_cause: assert property ($changed(tx_np_word[11]) |-> age_r <= 4'h6)
    else $error("toggle moved without page");
  a_partner_clear: assert property (down_r >= 4'h4 && rd && paddr == 8'h20 |-> prdata == 32'h0)
    else $error("partner page kept after link loss");
  a_partner_np_clr: assert property (down_r >= 4'h4 && rd && paddr == 8'h18 |-> !prdata[3])
    else $error("partner next page bit kept after link loss");
endmodule
bind fanp_top fanp_checker u_chk (
  .pclk         (pclk),
  .presetn      (presetn),
  .psel         (psel),
  .penable      (penable),
  .pwrite       (pwrite),
  .paddr        (paddr),
  .prdata       (prdata),
  .pready       (pready),
  .link_up      (link_up),
  .base_page_rx (base_page_rx),
  .next_page_rx (next_page_rx),
  .np_loaded    (np_loaded),
  .tx_np_word   (tx_np_word),
  .tx_np_valid  (tx_np_valid)
);

// ===== fanp_link_partner.sv
// Behavioural fiber link partner driving the receive-side events
`timescale 1ns/1ns
module fanp_link_partner (
  // Clock
  input  wire        pclk,
  // Receive events towards the bank
  output reg         link_up,
  output reg         sync_ok,
  output reg         cfg_valid,
  output reg  [15:0] cfg_word,
  output reg         base_page_rx,
  output reg         next_page_rx,
  output reg  [15:0] rx_code_word
);
  // Link starts down; code lines hold junk outside their pulses
  initial begin
    {link_up, sync_ok, cfg_valid, base_page_rx, next_page_rx} = 5'h0;
    cfg_word     = 16'hffff;
    rx_code_word = 16'hffff;
  end
  // Line state changes on a clock edge only
  task automatic set_link(input logic up, input logic sync);
    @(posedge pclk);
    link_up <= up;
    sync_ok <= sync;
  endtask
  // One page per pulse; the word is inverted after so stale data never looks valid
  task automatic send_page(input logic nxt, input logic [15:0] w);
    @(posedge pclk);
    base_page_rx <= ~nxt;
    next_page_rx <= nxt;
    rx_code_word <= w;
    @(posedge pclk);
    base_page_rx <= 1'b0;
    next_page_rx <= 1'b0;
    rx_code_word <= ~w;
  endtask
  // Three identical config groups, as a partner repeats its base word
  task automatic send_cfg(input logic [15:0] w);
    repeat (3) begin
      @(posedge pclk);
      cfg_valid <= 1'b1;
      cfg_word  <= w;
      @(posedge pclk);
      cfg_valid <= 1'b0;
      cfg_word  <= ~w;
    end
  endtask
endmodule

// ===== testbench.sv
// Self-checking bench for the fiber next-page register bank
`timescale 1ns/1ns
module testbench;
  typedef struct packed {logic w; logic [7:0] a; logic [15:0] d, e; logic err, v;} fanp_row_t;
  reg          pclk         = 1'b0;
  reg          presetn      = 1'b0;
  reg          psel         = 1'b0;
  reg          penable      = 1'b0;
  reg          pwrite       = 1'b0;
  reg  [7:0]   paddr        = 8'h0;
  reg  [31:0]  pwdata       = 32'h0;
  reg  [3:0]   pstrb        = 4'h3;
  wire [31:0]  prdata;
  wire [15:0]  cfg_word, rx_code_word, tx_np_word;
  wire         pready, pslverr, link_up, sync_ok, cfg_valid, base_page_rx, next_page_rx;
  wire         np_loaded, tx_np_valid, irq;
  logic [31:0] rdat;
  logic        rerr;
  int          num_errors   = 0;
  int          total_checks = 0;
  int          i;
  // Register walk: mode field in 0x24 bits 1:0 drives the capability bits
  fanp_row_t rows [17] = '{
    {1'b0, 8'h18, 16'h0, 16'h0004, 1'b0, 1'b1}, {1'b0, 8'h1c, 16'h0, 16'h2001, 1'b0, 1'b1},
    {1'b0, 8'h20, 16'h0, 16'h0000, 1'b0, 1'b1}, {1'b0, 8'h3c, 16'h0, 16'hc000, 1'b0, 1'b1},
    {1'b0, 8'h24, 16'h0, 16'h0005, 1'b0, 1'b1}, {1'b0, 8'h40, 16'h0, 16'h0000, 1'b1, 1'b1},
    {1'b1, 8'h1c, 16'hffff, 16'h0, 1'b0, 1'b1}, {1'b0, 8'h1c, 16'h0, 16'hb7ff, 1'b0, 1'b1},
    {1'b1, 8'h24, 16'h0004, 16'h0, 1'b0, 1'b0}, {1'b0, 8'h3c, 16'h0, 16'h0000, 1'b0, 1'b0},
    {1'b1, 8'h1c, 16'hffff, 16'h0, 1'b0, 1'b0},
    {1'b1, 8'h24, 16'h0006, 16'h0, 1'b0, 1'b0}, {1'b0, 8'h3c, 16'h0, 16'hc000, 1'b0, 1'b0},
    {1'b1, 8'h24, 16'h0007, 16'h0, 1'b0, 1'b0}, {1'b0, 8'h3c, 16'h0, 16'hc000, 1'b0, 1'b0},
    {1'b1, 8'h24, 16'h0005, 16'h0, 1'b0, 1'b1}, {1'b0, 8'h24, 16'h0, 16'h0005, 1'b0, 1'b1}};
  fanp_top DUT (
    .pclk         (pclk),
    .presetn      (presetn),
    .psel         (psel),
    .penable      (penable),
    .pwrite       (pwrite),
    .paddr        (paddr),
    .pwdata       (pwdata),
    .pstrb        (pstrb),
    .prdata       (prdata),
    .pready       (pready),
    .pslverr      (pslverr),
    .link_up      (link_up),
    .sync_ok      (sync_ok),
    .cfg_valid    (cfg_valid),
    .cfg_word     (cfg_word),
    .base_page_rx (base_page_rx),
    .next_page_rx (next_page_rx),
    .rx_code_word (rx_code_word),
    .np_loaded    (np_loaded),
    .tx_np_word   (tx_np_word),
    .tx_np_valid  (tx_np_valid),
    .irq          (irq)
  );
  fanp_link_partner lp (
    .pclk         (pclk),
    .link_up      (link_up),
    .sync_ok      (sync_ok),
    .cfg_valid    (cfg_valid),
    .cfg_word     (cfg_word),
    .base_page_rx (base_page_rx),
    .next_page_rx (next_page_rx),
    .rx_code_word (rx_code_word)
  );
  // 100 MHz clock
  always #5 pclk = ~pclk;
  task automatic close_out;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {16'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n == 16) begin
      num_errors++;
      close_out;
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    apb(1'b0, a, 16'h0);
    chk(rdat, {16'h0, e}, "read data");
  endtask
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    // table of reset values and modes
    for (i = 0; i < 17; i++) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      // Transmit writes pulse the load only in 1000BASE-X, one cycle after the access
      if (rows[i].w && rows[i].a == 8'h1c) begin
        @(posedge pclk);
        chk({31'h0, np_loaded}, {31'h0, rows[i].v}, "load pulse");
      end
      if (!rows[i].w) chk(rdat, {16'h0, rows[i].e}, "row data");
      chk({31'h0, rerr}, {31'h0, rows[i].err}, "row error");
      if (!rows[i].w) chk({31'h0, tx_np_valid}, {31'h0, rows[i].v}, "row valid");
    end
    $display("register table done");
    lp.set_link(1'b1, 1'b1);
    apb(1'b1, 8'h2c, 16'h0007);
    lp.send_page(1'b0, 16'h8000);
    repeat (6) @(posedge pclk);
    rd(8'h18, 16'h000e);
    rd(8'h18, 16'h000c);
    chk({31'h0, irq}, 32'h1, "irq raised");
    rd(8'h1c, 16'hbfff);
    chk({16'h0, tx_np_word}, 32'hbfff, "tx word");
    lp.send_page(1'b1, 16'h5a5a);
    repeat (6) @(posedge pclk);
    rd(8'h20, 16'h5a5a);
    rd(8'h1c, 16'hb7ff);
    rd(8'h28, 16'h0003);
    apb(1'b1, 8'h30, 16'h0007);
    rd(8'h28, 16'h0000);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    $display("page receive done");
    lp.set_link(1'b0, 1'b1);
    repeat (6) @(posedge pclk);
    rd(8'h20, 16'h0000);
    rd(8'h18, 16'h0006);
    rd(8'h28, 16'h0004);
    chk({31'h0, irq}, 32'h1, "irq link");
    apb(1'b1, 8'h2c, 16'h0000);
    // Enable lands at the access edge, the registered irq follows one edge later
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0, "irq masked");
    $display("link loss done");
    lp.set_link(1'b1, 1'b1);
    apb(1'b1, 8'h24, 16'h0001);
    lp.send_cfg(16'h1234);
    repeat (6) @(posedge pclk);
    rd(8'h18, 16'h0004);
    apb(1'b1, 8'h24, 16'h0005);
    lp.send_cfg(16'h1234);
    repeat (6) @(posedge pclk);
    rd(8'h18, 16'h0005);
    lp.set_link(1'b1, 1'b0);
    repeat (6) @(posedge pclk);
    rd(8'h18, 16'h0004);
    $display("partner ability done");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h1c, 16'h2001);
    rd(8'h18, 16'h0004);
    $display("second reset done");
    close_out;
  end
endmodule
